// File: rtl/fcct_timer.sv
// Contract
// - Overflow flag sets when counter wraps from modulo value to zero.
// - Flag clears by status read while set then zero write; overflow between voids it.
// - Overflow interrupt asserts only while enable and flag are both one.
// - Halt bit freezes the counter; reset sets halt.
// - Clear bit zeroes counter and prescaler, self-clears, reads zero.
// - Halt and clear written together leave counter stopped at zero.
// - Clock select picks bus clock divided 1..64 or external pin.
// - High byte read latches low byte until low byte is read.
// - Counter equal to modulo sets flag and restarts at zero.
// - Modulo high write suppresses overflow flag until low byte written.
// - Reset sets both modulo bytes to all ones.
// - Channel flag sets on capture edge or compare match.
// - Channel flag clears by read while set then zero write; events win.
// - Channel interrupt asserts when flag and channel enable are set.
// - Buffered bit on channels 0 and 2 disables the odd partner.
// - Mode bit A selects compare or capture, or preset level when idle.
// - Edge/level field selects pin release, capture edge or compare action.
// - Toggle-on-wrap toggles compare pin at every overflow.
// - Overflow action beats a simultaneous compare when toggle-on-wrap set.
// - Full duty force gives constant high output from next period; the code applies it only while toggle-on-wrap is clear.
// - Without toggle-on-wrap, compares reassert current state, giving 0% duty.
// - Buffered pair switches to last written value set at each overflow.
// - Channel value high write suppresses compares until low byte written.
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
module fcct_timer
  import fcct_pkg::*;
#(
  parameter int DIV_W = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ext_clk_i,
  input wire logic [NCH-1:0] chan_pin_i,
  output logic [NCH-1:0] chan_pin_o,
  output logic [NCH-1:0] chan_pin_oe_o,
  output logic ovf_irq_o,
  output logic [NCH-1:0] chan_irq_o
);

  if (DIV_W != DIV_LOG) begin : g_chk
    $error("DIV_W must equal the prescaler depth");
  end

  // ********************************
  // Bus slave
  // ********************************
  logic ack_r;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;
  logic acc;
  logic wr;
  logic rd;
  logic map_ok;
  logic [IDX_W-1:0] idx;
  logic [A_LAST:0] hit;
  fcct_csc_t wcsc;

  assign acc = cyc_i & stb_i & ~ack_r;
  assign wr = acc & we_i & sel_i[0];
  assign rd = acc & ~we_i;
  assign idx = adr_i[6:2];
  assign map_ok = ~adr_i[7] & (adr_i[1:0] == 2'h0);
  assign wcsc = dat_i[7:0];
  assign ack_o = ack_r;
  assign dat_o = {24'h000000, rd_r};

  always_comb begin
    for (int k = 0; k <= A_LAST; k++) begin
      hit[k] = map_ok & (idx == IDX_W'(k));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rd_r <= 8'h00;
    end else begin
      ack_r <= acc;
      if (rd) begin
        rd_r <= rd_nxt;
      end
    end
  end

  // ********************************
  // Counter and prescaler
  // ********************************
  function automatic logic presc_tick(input logic [2:0] ps, input logic [DIV_W-1:0] d);
    logic [DIV_W-1:0] m;
    m = DIV_W'((8'h01 << ps) - 8'h01);
    return &(d | ~m);
  endfunction

  logic ovf_r;
  logic oie_r;
  logic halt_r;
  logic [2:0] ps_r;
  logic ovf_arm_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [DIV_W-1:0] div_r;
  logic [CNT_W-1:0] mod_r;
  logic mod_lock_r;
  logic [7:0] lat_r;
  logic lat_v_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic tick;
  logic run;
  logic ovf_ev;
  logic wr_tsc;
  logic clr_req;

  assign wr_tsc = wr & hit[A_TSC];
  assign clr_req = wr_tsc & dat_i[TSC_CLR];
  assign tick = (ps_r == PS_EXT) ? (ext_s2_r & ~ext_s3_r)
                                 : presc_tick(ps_r, div_r);
  assign run = ~halt_r & tick;
  assign ovf_ev = run & (cnt_r == mod_r);
  assign cnt_nxt = ovf_ev ? '0 : cnt_r + 16'h0001;

  // External clock synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_clk_i;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      div_r <= '0;
    end else if (clr_req) begin
      cnt_r <= '0;
      div_r <= '0;
    end else begin
      div_r <= div_r + DIV_W'(1);
      if (run) begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oie_r <= 1'b0;
      halt_r <= 1'b1;
      ps_r <= 3'h0;
    end else if (wr_tsc) begin
      oie_r <= dat_i[TSC_OIE];
      halt_r <= dat_i[TSC_HALT];
      ps_r <= dat_i[2:0];
    end
  end

  // Overflow flag, set beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_r <= 1'b0;
      ovf_arm_r <= 1'b0;
    end else begin
      if (ovf_ev && !mod_lock_r) begin
        ovf_r <= 1'b1;
      end else if (wr_tsc && !dat_i[TSC_OVF] && ovf_arm_r) begin
        ovf_r <= 1'b0;
      end
      if (ovf_ev) begin
        ovf_arm_r <= 1'b0;
      end else if (rd && hit[A_TSC] && ovf_r) begin
        ovf_arm_r <= 1'b1;
      end else if (wr_tsc) begin
        ovf_arm_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_r <= MOD_RST;
      mod_lock_r <= 1'b0;
    end else if (wr && hit[A_MODH]) begin
      mod_r[15:8] <= dat_i[7:0];
      mod_lock_r <= 1'b1;
    end else if (wr && hit[A_MODL]) begin
      mod_r[7:0] <= dat_i[7:0];
      mod_lock_r <= 1'b0;
    end
  end

  // Low byte latch for coherent reads
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_req) begin
      lat_r <= 8'h00;
      lat_v_r <= 1'b0;
    end else if (rd && hit[A_CNTH] && !lat_v_r) begin
      lat_r <= cnt_r[7:0];
      lat_v_r <= 1'b1;
    end else if (rd && hit[A_CNTL]) begin
      lat_v_r <= 1'b0;
    end
  end

  // ********************************
  // Channels
  // ********************************
  fcct_csc_t [NCH-1:0] csc_r;
  logic [NCH-1:0][CNT_W-1:0] val_r;
  logic [NCH-1:0][CNT_W-1:0] cval;
  logic [NCH-1:0] vlock_r;
  logic [NCH-1:0] arm_r;
  logic [NCH-1:0] pout_r;
  logic [NCH-1:0] maxe_r;
  logic [NCH-1:0] pin_s1_r;
  logic [NCH-1:0] pin_s2_r;
  logic [NCH-1:0] pin_s3_r;
  logic [NCH-1:0] pin_o_r;
  logic [NCH-1:0] oe_r;
  logic [NCH-1:0] irq_r;
  logic ovf_irq_r;
  logic [1:0] sel_r;
  logic [1:0] pend_r;
  logic [NCH-1:0] dis;
  logic [NCH-1:0] bufm;
  logic [NCH-1:0] act;
  logic [NCH-1:0] cmpm;
  logic [NCH-1:0] capm;
  logic [NCH-1:0] usep;
  logic [NCH-1:0] vlk;
  logic [NCH-1:0] match;
  logic [NCH-1:0] cap;
  logic [NCH-1:0] ovtog;
  logic [NCH-1:0] ev;
  logic [NCH-1:0] pout_nxt;
  logic [NCH-1:0] pin_nxt;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      dis[i] = i[0] & csc_r[i & 2].msb;
      bufm[i] = ~i[0] & csc_r[i].msb;
      act[i] = (csc_r[i].els != EL_OFF) & ~dis[i];
      cmpm[i] = act[i] & (csc_r[i].msa | bufm[i]);
      capm[i] = act[i] & ~cmpm[i];
      usep[i] = bufm[i] & sel_r[i >> 1];
      cval[i] = usep[i] ? val_r[i | 1] : val_r[i];
      vlk[i] = usep[i] ? vlock_r[i | 1] : vlock_r[i];
      match[i] = cmpm[i] & run & (cnt_nxt == cval[i]) & ~vlk[i];
      cap[i] = capm[i] & ((csc_r[i].els[0] & pin_s2_r[i] & ~pin_s3_r[i])
                | (csc_r[i].els[1] & ~pin_s2_r[i] & pin_s3_r[i]));
      ovtog[i] = cmpm[i] & csc_r[i].tov & ovf_ev;
      ev[i] = match[i] | cap[i];
      pout_nxt[i] = pout_r[i];
      if (!act[i]) begin
        pout_nxt[i] = ~csc_r[i].msa;
      end else if (ovtog[i]) begin
        pout_nxt[i] = ~pout_r[i];
      end else if (match[i]) begin
        unique case (csc_r[i].els)
          EL_OFF: pout_nxt[i] = pout_r[i];
          EL_TOG: pout_nxt[i] = ~pout_r[i];
          EL_CLR: pout_nxt[i] = 1'b0;
          EL_SET: pout_nxt[i] = 1'b1;
        endcase
      end
      pin_nxt[i] = (maxe_r[i] & ~csc_r[i].tov) | pout_nxt[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      csc_r <= '0;
      val_r <= '0;
      vlock_r <= '0;
      arm_r <= '0;
      pout_r <= '0;
      maxe_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr && hit[A_CSC0 + i] && !dis[i]) begin
          csc_r[i].ie <= wcsc.ie;
          csc_r[i].msb <= ~i[0] & wcsc.msb;
          csc_r[i].msa <= wcsc.msa;
          csc_r[i].els <= wcsc.els;
          csc_r[i].tov <= wcsc.tov;
          csc_r[i].max <= wcsc.max;
        end
        if (ev[i]) begin
          csc_r[i].flag <= 1'b1;
        end else if (wr && hit[A_CSC0 + i] && !wcsc.flag && arm_r[i]) begin
          csc_r[i].flag <= 1'b0;
        end
        if (ev[i]) begin
          arm_r[i] <= 1'b0;
        end else if (rd && hit[A_CSC0 + i] && csc_r[i].flag && !dis[i]) begin
          arm_r[i] <= 1'b1;
        end else if (wr && hit[A_CSC0 + i]) begin
          arm_r[i] <= 1'b0;
        end
        if (cap[i]) begin
          val_r[i] <= cnt_r;
        end else if (wr && hit[A_CVAL0 + 2 * i]) begin
          val_r[i][15:8] <= dat_i[7:0];
        end else if (wr && hit[A_CVAL0 + 2 * i + 1]) begin
          val_r[i][7:0] <= dat_i[7:0];
        end
        if (wr && hit[A_CVAL0 + 2 * i]) begin
          vlock_r[i] <= 1'b1;
        end else if (wr && hit[A_CVAL0 + 2 * i + 1]) begin
          vlock_r[i] <= 1'b0;
        end
        pout_r[i] <= pout_nxt[i];
        if (ovf_ev) begin
          maxe_r[i] <= csc_r[i].max;
        end
      end
    end
  end

  // Buffered pair selection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_r <= 2'h0;
      pend_r <= 2'h0;
    end else begin
      for (int p = 0; p < NCH / 2; p++) begin
        if (!csc_r[2 * p].msb) begin
          sel_r[p] <= 1'b0;
          pend_r[p] <= 1'b0;
        end else begin
          if (wr && (hit[A_CVAL0 + 4 * p] || hit[A_CVAL0 + 4 * p + 1])) begin
            pend_r[p] <= 1'b0;
          end else if (wr && (hit[A_CVAL0 + 4 * p + 2] || hit[A_CVAL0 + 4 * p + 3])) begin
            pend_r[p] <= 1'b1;
          end
          if (ovf_ev) begin
            sel_r[p] <= pend_r[p];
          end
        end
      end
    end
  end

  // Pin synchronisers and registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_o_r <= '0;
      oe_r <= '0;
      irq_r <= '0;
      ovf_irq_r <= 1'b0;
    end else begin
      pin_s1_r <= chan_pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_o_r <= pin_nxt;
      oe_r <= cmpm;
      ovf_irq_r <= ovf_r & oie_r;
      for (int i = 0; i < NCH; i++) begin
        irq_r[i] <= csc_r[i].flag & csc_r[i].ie & ~dis[i];
      end
    end
  end

  assign chan_pin_o = pin_o_r;
  assign chan_pin_oe_o = oe_r;
  assign chan_irq_o = irq_r;
  assign ovf_irq_o = ovf_irq_r;

  // ********************************
  // Read mux
  // ********************************
  always_comb begin
    rd_nxt = 8'h00;
    if (hit[A_TSC]) begin
      rd_nxt = {ovf_r, oie_r, halt_r, 2'h0, ps_r};
    end
    if (hit[A_CNTH]) begin
      rd_nxt = cnt_r[15:8];
    end
    if (hit[A_CNTL]) begin
      rd_nxt = lat_v_r ? lat_r : cnt_r[7:0];
    end
    if (hit[A_MODH]) begin
      rd_nxt = mod_r[15:8];
    end
    if (hit[A_MODL]) begin
      rd_nxt = mod_r[7:0];
    end
    for (int i = 0; i < NCH; i++) begin
      if (hit[A_CSC0 + i] && !dis[i]) begin
        rd_nxt = csc_r[i];
      end
      if (hit[A_CVAL0 + 2 * i]) begin
        rd_nxt = val_r[i][15:8];
      end
      if (hit[A_CVAL0 + 2 * i + 1]) begin
        rd_nxt = val_r[i][7:0];
      end
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_stop_clear;
    clr_req && dat_i[TSC_HALT] ##1 !wr_tsc;
  endsequence

  property p_ovf_set;
    ovf_ev && !mod_lock_r |=> ovf_r;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_ovf_w1;
    wr_tsc && dat_i[TSC_OVF] && ovf_r |=> ovf_r;
  endproperty
  a_ovf_w1: assert property (p_ovf_w1) else $error("one write changed flag");

  property p_ovf_irq;
    ovf_r && oie_r |=> ovf_irq_o ##0 (ovf_irq_o == $past(ovf_r && oie_r));
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq wrong");

  property p_halt;
    halt_r && !clr_req |=> $stable(cnt_r);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved while halted");

  property p_clear;
    clr_req |=> cnt_r == 16'h0000 && div_r == '0 && !lat_v_r;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero");

  property p_stop_zero;
    s_stop_clear |-> cnt_r == 16'h0000 && halt_r;
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("not stopped at zero");

  property p_ext_hold;
    ps_r == PS_EXT && !(ext_s2_r && !ext_s3_r) && !clr_req |=> $stable(cnt_r);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("count without edge");

  property p_latch;
    rd && hit[A_CNTH] && lat_v_r && !clr_req |=> $stable(lat_r) && lat_v_r;
  endproperty
  a_latch: assert property (p_latch) else $error("latch overwritten");

  property p_mod_lock;
    mod_lock_r && !ovf_r |=> !ovf_r;
  endproperty
  a_mod_lock: assert property (p_mod_lock) else $error("flag set while locked");

  property p_chan_irq;
    csc_r[0].flag && csc_r[0].ie |=> chan_irq_o[0];
  endproperty
  a_chan_irq: assert property (p_chan_irq) else $error("channel irq missing");

endmodule // fcct_timer

// File: common/fcct_pkg.sv
package fcct_pkg;
  localparam int NCH = 4;
  localparam int CNT_W = 16;
  localparam int IDX_W = 5;
  localparam int DIV_LOG = 6;
  // ********************************
  // Register indices (byte addr = 4 * index)
  // ********************************
  localparam logic [IDX_W-1:0] A_TSC = 5'h00;
  localparam logic [IDX_W-1:0] A_CNTH = 5'h01;
  localparam logic [IDX_W-1:0] A_CNTL = 5'h02;
  localparam logic [IDX_W-1:0] A_MODH = 5'h03;
  localparam logic [IDX_W-1:0] A_MODL = 5'h04;
  localparam logic [IDX_W-1:0] A_CSC0 = 5'h05;
  localparam logic [IDX_W-1:0] A_CVAL0 = 5'h09;
  localparam int A_LAST = 16;
  // ********************************
  // Status/control fields, field codes and modulo reset value
  // ********************************
  localparam int TSC_OVF = 7;
  localparam int TSC_OIE = 6;
  localparam int TSC_HALT = 5;
  localparam int TSC_CLR = 4;
  localparam int CSC_FLAG = 7;
  localparam logic [2:0] PS_EXT = 3'h7;
  localparam logic [CNT_W-1:0] MOD_RST = 16'hffff;
  localparam logic [1:0] EL_OFF = 2'h0;
  localparam logic [1:0] EL_TOG = 2'h1;
  localparam logic [1:0] EL_CLR = 2'h2;
  localparam logic [1:0] EL_SET = 2'h3;
  typedef struct packed {
    logic flag;
    logic ie;
    logic msb;
    logic msa;
    logic [1:0] els;
    logic tov;
    logic max;
  } fcct_csc_t;
endpackage

// File: tb/tb_top.sv
module tb_top
  import fcct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic ext_clk_i = 1'b0;
  logic [NCH-1:0] chan_pin_i = 4'h0;
  logic [NCH-1:0] chan_pin_o;
  logic [NCH-1:0] chan_pin_oe_o;
  logic ovf_irq_o;
  logic [NCH-1:0] chan_irq_o;
  int err_count = 0;
  int compares = 0;
  logic [31:0] rd;
  logic [15:0] v;

  fcct_timer #(.DIV_W(6)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ext_clk_i(ext_clk_i), .chan_pin_i(chan_pin_i), .chan_pin_o(chan_pin_o),
    .chan_pin_oe_o(chan_pin_oe_o), .ovf_irq_o(ovf_irq_o), .chan_irq_o(chan_irq_o));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // ********************************
  // Bus access and comparison
  // ********************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    // Only the watchdog ends a missing acknowledge
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input int idx, input logic [7:0] d);
    bus({1'b0, 5'(idx), 2'b00}, 1'b1, d);
  endtask

  task automatic rdr(input int idx);
    bus({1'b0, 5'(idx), 2'b00}, 1'b0, 8'h00);
  endtask

  task automatic rdc(input int idx, input logic [7:0] e);
    rdr(idx);
    chk(rd, {24'h0, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic rcnt(output logic [15:0] c);
    rdr(A_CNTH);
    c[15:8] = rd[7:0];
    rdr(A_CNTL);
    c[7:0] = rd[7:0];
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    err_count++;
    $display("FAIL %0t watchdog expired", $time);
    summarize();
  end

  // ********************************
  // Test sequence
  // ********************************
  initial begin
    cyc(3);
    rst_i <= 1'b0;
    rdc(A_TSC, 8'h20);
    rdc(A_MODH, 8'hff);
    rdc(A_MODL, 8'hff);
    rdc(A_CNTH, 8'h00);
    rdc(A_CNTL, 8'h00);
    for (int c = 0; c < NCH; c++) begin
      rdc(A_CSC0 + c, 8'h00);
    end
    bus(8'h80, 1'b1, 8'h55);
    bus(8'h80, 1'b0, 8'h00);
    chk(rd, 32'h0);
    chk({ovf_irq_o, chan_irq_o, chan_pin_oe_o}, 32'h0);
    chk(chan_pin_o, 32'h0000000f);
    $display("reset test done");

    for (int k = 0; k < 7; k++) begin
      wr(A_TSC, 8'h30);
      wr(A_TSC, {5'h00, 3'(k)});
      cyc(640);
      wr(A_TSC, {5'h04, 3'(k)});
      rcnt(v);
      chk(32'((int'(v) >= (643 >> k) - 1) && (int'(v) <= (643 >> k) + 1)), 32'h1);
    end
    wr(A_TSC, 8'h30);
    wr(A_TSC, {5'h00, PS_EXT});
    repeat (10) begin
      ext_clk_i <= 1'b1;
      cyc(3);
      ext_clk_i <= 1'b0;
      cyc(3);
    end
    cyc(6);
    wr(A_TSC, {5'h04, PS_EXT});
    rcnt(v);
    chk(v, 16'd10);
    $display("clock select test done");

    wr(A_TSC, 8'h30);
    wr(A_TSC, 8'h00);
    rdr(A_CNTH);
    chk(rd, 32'h0);
    cyc(100);
    rdr(A_CNTH);
    rdr(A_CNTL);
    chk(32'(rd >= 1 && rd <= 8), 32'h1);
    wr(A_TSC, 8'h30);
    rdc(A_TSC, 8'h20);
    rcnt(v);
    chk(v, 16'h0);
    cyc(20);
    rcnt(v);
    chk(v, 16'h0);
    $display("counter read test done");

    wr(A_MODH, 8'h00);
    wr(A_MODL, 8'h05);
    wr(A_CVAL0, 8'h00);
    wr(A_CVAL0 + 1, 8'h03);
    wr(A_CSC0, 8'h54);
    wr(A_TSC, 8'h00);
    cyc(20);
    wr(A_TSC, 8'h20);
    rdc(A_TSC, 8'ha0);
    chk(chan_pin_oe_o[0], 1'b1);
    chk(chan_irq_o[0], 1'b1);
    chk(ovf_irq_o, 1'b0);
    rdc(A_CSC0, 8'hd4);
    wr(A_CSC0, 8'h54);
    rdc(A_CSC0, 8'h54);
    chk(chan_irq_o[0], 1'b0);
    wr(A_TSC, 8'he0);
    cyc(2);
    chk(ovf_irq_o, 1'b1);
    rdc(A_TSC, 8'he0);
    wr(A_TSC, 8'he0);
    rdc(A_TSC, 8'he0);
    wr(A_TSC, 8'h60);
    rdc(A_TSC, 8'h60);
    cyc(2);
    chk(ovf_irq_o, 1'b0);
    wr(A_MODH, 8'h00);
    wr(A_TSC, 8'h00);
    cyc(20);
    wr(A_TSC, 8'h20);
    rdc(A_TSC, 8'h20);
    wr(A_MODL, 8'h05);
    wr(A_TSC, 8'h00);
    cyc(20);
    wr(A_TSC, 8'h20);
    rdc(A_TSC, 8'ha0);
    wr(A_CSC0, 8'h18);
    wr(A_TSC, 8'h00);
    cyc(20);
    chk(chan_pin_o[0], 1'b0);
    wr(A_CSC0, 8'h19);
    cyc(20);
    chk(chan_pin_o[0], 1'b1);
    wr(A_CSC0, 8'h18);
    cyc(20);
    chk(chan_pin_o[0], 1'b0);
    // Arm, then let an overflow void the zero write
    rdr(A_TSC);
    cyc(10);
    wr(A_TSC, 8'h20);
    rdc(A_TSC, 8'ha0);
    $display("overflow and compare test done");

    wr(A_TSC, 8'h30);
    for (int m = 1; m < 4; m++) begin
      wr(A_CSC0 + 1, {4'h0, 2'(m), 2'h0});
      chan_pin_i[1] <= 1'b1;
      cyc(8);
      rdr(A_CSC0 + 1);
      chk(rd[7], 1'(m != 2));
      wr(A_CSC0 + 1, {4'h0, 2'(m), 2'h0});
      chan_pin_i[1] <= 1'b0;
      cyc(8);
      rdr(A_CSC0 + 1);
      chk(rd[7], 1'(m != 1));
      wr(A_CSC0 + 1, {4'h0, 2'(m), 2'h0});
    end
    rdc(A_CSC0 + 1, 8'h0c);
    $display("capture test done");

    wr(A_CSC0, 8'h28);
    wr(A_CSC0 + 1, 8'h44);
    rdc(A_CSC0 + 1, 8'h00);
    chk({chan_irq_o[1], chan_pin_oe_o[1]}, 2'b00);
    wr(A_CSC0 + 2, 8'h10);
    chk(chan_pin_o[2], 1'b0);
    wr(A_CSC0, 8'h00);
    $display("buffered pairing test done");
    summarize();
  end
endmodule // tb_top
